// file: design/pio_pkg.sv
// How it works
// RULE1: cell has input, output, tri-state sections
// RULE2: bypass skips delay and capture, feeds core
// RULE3: optional fixed input delay before capture
// RULE4: bottom edge adds five-bit dynamic delay
// RULE5: single rate captures with one register
// RULE6: double rate samples both clock edges
// RULE7: rise output carries positive-edge sample
// RULE8: fall output: registered input or negative-edge
// RULE9: core supplies primary and secondary out data
// RULE10: tri-state control passed to pad beside data
// RULE11: one system clock times all sections
// RULE12: local reset forces set or reset value
// RULE13: right edge only takes strobe clocks, polarity
// RULE14: right edge input has memory capture logic
// RULE15: double rate out: primary high, secondary low
// RULE16: capture registers update only with enable
package pio_pkg;

   // ---------------------------------------------------------
   // bus and map
   // ---------------------------------------------------------
   localparam int          ADDR_W      = 8;
   localparam int          DATA_W      = 32;
   localparam logic [7:0]  REG_CTRL    = 8'h00;
   localparam logic [7:0]  REG_DLY     = 8'h04;
   localparam logic [7:0]  REG_DIV     = 8'h08;
   localparam logic [7:0]  REG_STAT    = 8'h0c;
   localparam logic [1:0]  RESP_OKAY   = 2'h0;
   localparam logic [1:0]  RESP_SLVERR = 2'h2;

   // ---------------------------------------------------------
   // fields and reset values
   // ---------------------------------------------------------
   localparam int          DLY_W       = 5;
   localparam int          DIV_W       = 8;
   localparam logic [7:0]  DIV_RST     = 8'h02;
   localparam logic [4:0]  DLY_RST     = 5'h00;

   typedef struct packed {
      logic [24:0] rsvd;
      logic        set_val;
      logic        tri_reg;
      logic        ddr_out;
      logic        ddr_in;
      logic        dyn_en;
      logic        fix_en;
      logic        bypass;
   } pio_ctrl_t;

   localparam pio_ctrl_t CTRL_RST = '{default: 1'b0};

   typedef struct packed {
      logic [26:0] rsvd;
      logic        phase;
      logic        tri_st;
      logic        pad;
      logic        fall;
      logic        rise;
   } pio_stat_t;

   typedef enum logic [3:0] {
      EDGE_LEFT   = 4'h1,
      EDGE_TOP    = 4'h2,
      EDGE_BOTTOM = 4'h4,
      EDGE_RIGHT  = 4'h8
   } pio_edge_t;

endpackage

// file: design/pio_delay_line.sv
module pio_delay_line #(
   parameter int DEPTH = 64
) (
   // clock and reset
   input  wire logic                     clk,
   input  wire logic                     rst,
   // data
   input  wire logic                     d,
   input  wire logic [$clog2(DEPTH)-1:0] tap,
   output logic                          q
);

   // ---------------------------------------------------------
   // tapped shift line
   // ---------------------------------------------------------
   logic [DEPTH-1:0] sr_q;

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         sr_q <= '0;
      end else begin
         sr_q <= {sr_q[DEPTH-2:0], d};
      end
   end

   // tap zero still costs one register so all taps share timing
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         q <= 1'b0;
      end else if (tap == '0) begin
         q <= d;
      end else begin
         q <= sr_q[tap - 1'b1];
      end
   end

endmodule

// file: design/pio_capture.sv
module pio_capture (
   // clock and reset
   input  wire logic clk,
   input  wire logic rst,
   // control
   input  wire logic ce,
   input  wire logic srst,
   input  wire logic set_val,
   input  wire logic ddr,
   input  wire logic swap,
   // data and sample points
   input  wire logic d,
   input  wire logic rise_evt,
   input  wire logic fall_evt,
   output logic      rise_q,
   output logic      fall_q
);

   // ---------------------------------------------------------
   // capture pair
   // ---------------------------------------------------------
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         rise_q <= 1'b0;
      end else if (srst) begin
         rise_q <= set_val; // RULE12
      end else if (ce && ddr) begin // RULE16
         if ((rise_evt && !swap) || (fall_evt && swap)) begin
            rise_q <= d; // RULE7
         end
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         fall_q <= 1'b0;
      end else if (srst) begin
         fall_q <= set_val; // RULE12
      end else if (ce) begin // RULE16
         if (!ddr && rise_evt) begin
            fall_q <= d; // RULE5 RULE8
         end else if (ddr && ((fall_evt && !swap) || (rise_evt && swap))) begin
            fall_q <= d; // RULE6 RULE8
         end
      end
   end

endmodule

// file: design/pio_cell.sv
// Design decisions made here: the AXI4-Lite slave port and the address map.
module pio_cell #(
   parameter pio_pkg::pio_edge_t EDGE      = pio_pkg::EDGE_LEFT,
   parameter int                 FIXED_DLY = 8,
   parameter int                 LINE_LEN  = 64
) (
   // clock and reset
   input  wire logic                          REF_CLK,
   input  wire logic                          RESET,
   // core side
   input  wire logic                          CE,
   input  wire logic                          LOCAL_RST,
   input  wire logic                          CORE_OUT_PRIMARY,
   input  wire logic                          CORE_OUT_SECONDARY,
   input  wire logic                          CORE_TRISTATE_CTL,
   output logic                               INPUT_BYPASS_DATA,
   output logic                               INPUT_BYPASS_CLOCK,
   output logic                               RISE_CAPTURE_OUT,
   output logic                               FALL_CAPTURE_OUT,
   // pad buffer side
   input  wire logic                          PAD_IN,
   output logic                               PAD_OUT,
   output logic                               PAD_TRISTATE_OUT,
   // strobe side, right edge only
   input  wire logic                          STROBE_READ_CLK_SHIFTED,
   input  wire logic                          STROBE_WRITE_CLK_SHIFTED,
   input  wire logic                          CAPTURE_POLARITY_CTL,
   // axi4-lite write
   input  wire logic [pio_pkg::ADDR_W-1:0]    S_AXI_AWADDR,
   input  wire logic                          S_AXI_AWVALID,
   output logic                               S_AXI_AWREADY,
   input  wire logic [pio_pkg::DATA_W-1:0]    S_AXI_WDATA,
   input  wire logic [pio_pkg::DATA_W/8-1:0]  S_AXI_WSTRB,
   input  wire logic                          S_AXI_WVALID,
   output logic                               S_AXI_WREADY,
   output logic [1:0]                         S_AXI_BRESP,
   output logic                               S_AXI_BVALID,
   input  wire logic                          S_AXI_BREADY,
   // axi4-lite read
   input  wire logic [pio_pkg::ADDR_W-1:0]    S_AXI_ARADDR,
   input  wire logic                          S_AXI_ARVALID,
   output logic                               S_AXI_ARREADY,
   output logic [pio_pkg::DATA_W-1:0]         S_AXI_RDATA,
   output logic [1:0]                         S_AXI_RRESP,
   output logic                               S_AXI_RVALID,
   input  wire logic                          S_AXI_RREADY
);

   localparam int TAP_W = $clog2(LINE_LEN);
   localparam logic IS_RIGHT  = (EDGE == pio_pkg::EDGE_RIGHT);
   localparam logic IS_BOTTOM = (EDGE == pio_pkg::EDGE_BOTTOM);

   // refuse settings the delay line cannot reach
   if (FIXED_DLY < 0 || FIXED_DLY + 31 >= LINE_LEN || LINE_LEN < 2) begin
      $error("pio_cell: FIXED_DLY or LINE_LEN out of range");
   end

   // ---------------------------------------------------------
   // helpers
   // ---------------------------------------------------------
   function automatic logic [31:0] merge(input logic [31:0] old,
                                         input logic [31:0] wd,
                                         input logic [3:0]  be);
      logic [31:0] r;
      r = old;
      for (int i = 0; i < 4; i++) begin
         if (be[i]) begin
            r[8*i +: 8] = wd[8*i +: 8];
         end
      end
      return r;
   endfunction

   function automatic logic known(input logic [7:0] a);
      return a == pio_pkg::REG_CTRL || a == pio_pkg::REG_DLY ||
             a == pio_pkg::REG_DIV  || a == pio_pkg::REG_STAT;
   endfunction

   // ---------------------------------------------------------
   // registers
   // ---------------------------------------------------------
   pio_pkg::pio_ctrl_t          ctrl_q;
   logic [pio_pkg::DLY_W-1:0]   dly_q;
   logic [pio_pkg::DIV_W-1:0]   div_q;
   logic [7:0]                  awaddr_q;
   logic [31:0]                 wdata_q;
   logic [3:0]                  wstrb_q;
   logic                        aw_have_q;
   logic                        w_have_q;
   logic                        aw_take;
   logic                        w_take;
   logic                        do_wr;
   logic                        ar_take;
   logic                        bvalid_d;
   logic                        rvalid_d;
   logic                        aw_have_d;
   logic                        w_have_d;

   assign aw_take = S_AXI_AWVALID && S_AXI_AWREADY;
   assign w_take  = S_AXI_WVALID && S_AXI_WREADY;
   assign do_wr   = aw_have_q && w_have_q && !S_AXI_BVALID;
   assign ar_take = S_AXI_ARVALID && S_AXI_ARREADY;

   assign aw_have_d = (aw_have_q || aw_take) && !do_wr;
   assign w_have_d  = (w_have_q || w_take) && !do_wr;
   assign bvalid_d  = do_wr || (S_AXI_BVALID && !S_AXI_BREADY);
   assign rvalid_d  = ar_take || (S_AXI_RVALID && !S_AXI_RREADY);

   // ---------------------------------------------------------
   // write channel
   // ---------------------------------------------------------
   always_ff @(posedge REF_CLK or posedge RESET) begin
      if (RESET) begin
         aw_have_q     <= 1'b0;
         w_have_q      <= 1'b0;
         S_AXI_AWREADY <= 1'b0;
         S_AXI_WREADY  <= 1'b0;
         S_AXI_BVALID  <= 1'b0;
      end else begin
         aw_have_q     <= aw_have_d;
         w_have_q      <= w_have_d;
         S_AXI_AWREADY <= !aw_have_d && !bvalid_d;
         S_AXI_WREADY  <= !w_have_d && !bvalid_d;
         S_AXI_BVALID  <= bvalid_d;
      end
   end

   always_ff @(posedge REF_CLK or posedge RESET) begin
      if (RESET) begin
         awaddr_q <= '0;
         wdata_q  <= '0;
         wstrb_q  <= '0;
      end else begin
         if (aw_take) begin
            awaddr_q <= S_AXI_AWADDR;
         end
         if (w_take) begin
            wdata_q <= S_AXI_WDATA;
            wstrb_q <= S_AXI_WSTRB;
         end
      end
   end

   always_ff @(posedge REF_CLK or posedge RESET) begin
      if (RESET) begin
         S_AXI_BRESP <= pio_pkg::RESP_OKAY;
      end else if (do_wr) begin
         S_AXI_BRESP <= known(awaddr_q) ? pio_pkg::RESP_OKAY
                                        : pio_pkg::RESP_SLVERR;
      end
   end

   // status is read-only; writes to it are accepted and dropped
   always_ff @(posedge REF_CLK or posedge RESET) begin
      if (RESET) begin
         ctrl_q <= pio_pkg::CTRL_RST;
         dly_q  <= pio_pkg::DLY_RST;
         div_q  <= pio_pkg::DIV_RST;
      end else if (do_wr) begin
         if (awaddr_q == pio_pkg::REG_CTRL) begin
            ctrl_q <= pio_pkg::pio_ctrl_t'(merge(ctrl_q, wdata_q, wstrb_q)
                                           & 32'h0000_007f);
         end
         if (awaddr_q == pio_pkg::REG_DLY && IS_BOTTOM) begin // RULE4
            dly_q <= wstrb_q[0] ? wdata_q[pio_pkg::DLY_W-1:0] : dly_q;
         end
         if (awaddr_q == pio_pkg::REG_DIV && wstrb_q[0]) begin
            div_q <= wdata_q[pio_pkg::DIV_W-1:0];
         end
      end
   end

   // ---------------------------------------------------------
   // system clock phase, one enable per edge
   // ---------------------------------------------------------
   logic [pio_pkg::DIV_W-1:0] cnt_q;
   logic                      sclk_q;
   logic                      tick;
   logic                      rise_tick;
   logic                      fall_tick;
   logic                      sclk_nx;
   logic [pio_pkg::DIV_W-1:0] half;

   // a zero divider would wrap the reload to 255, so it counts as one
   assign half      = (div_q == '0) ? pio_pkg::DIV_W'(1) : div_q;
   assign tick      = (cnt_q == '0);
   assign rise_tick = tick && !sclk_q;
   assign fall_tick = tick && sclk_q;
   assign sclk_nx   = tick ? !sclk_q : sclk_q;

   always_ff @(posedge REF_CLK or posedge RESET) begin // RULE11
      if (RESET) begin
         cnt_q  <= '0;
         sclk_q <= 1'b0;
      end else begin
         cnt_q  <= tick ? half - 1'b1 : cnt_q - 1'b1;
         sclk_q <= sclk_nx;
      end
   end

   // ---------------------------------------------------------
   // input section
   // ---------------------------------------------------------
   logic             pad_q;
   logic             dly_out;
   logic [TAP_W-1:0] tap;
   logic             strb_q;
   logic             rd_rise;
   logic             rd_fall;
   logic             use_strobe;
   logic             swap;

   always_ff @(posedge REF_CLK or posedge RESET) begin
      if (RESET) begin
         pad_q              <= 1'b0;
         INPUT_BYPASS_DATA  <= 1'b0;
         INPUT_BYPASS_CLOCK <= 1'b0;
      end else begin
         pad_q              <= PAD_IN;
         INPUT_BYPASS_DATA  <= ctrl_q.bypass && PAD_IN; // RULE2
         INPUT_BYPASS_CLOCK <= ctrl_q.bypass && PAD_IN; // RULE2
      end
   end

   assign tap = (ctrl_q.fix_en ? TAP_W'(FIXED_DLY) : TAP_W'(0)) // RULE3
              + ((ctrl_q.dyn_en && IS_BOTTOM) ? TAP_W'(dly_q)   // RULE4
                                              : TAP_W'(0));

   pio_delay_line #(
      .DEPTH (LINE_LEN)
   ) u_dly (
      .clk (REF_CLK),
      .rst (RESET),
      .d   (PAD_IN),
      .tap (tap),
      .q   (dly_out)
   );

   // memory strobe: on the right edge in ddr input mode, read strobe edges replace the system clock edges
   always_ff @(posedge REF_CLK or posedge RESET) begin
      if (RESET) begin
         strb_q <= 1'b0;
      end else begin
         strb_q <= STROBE_READ_CLK_SHIFTED;
      end
   end

   assign use_strobe = IS_RIGHT && ctrl_q.ddr_in; // RULE13 RULE14
   assign rd_rise    = STROBE_READ_CLK_SHIFTED && !strb_q;
   assign rd_fall    = !STROBE_READ_CLK_SHIFTED && strb_q;
   assign swap       = IS_RIGHT && CAPTURE_POLARITY_CTL; // RULE13

   pio_capture u_cap (
      .clk      (REF_CLK),
      .rst      (RESET),
      .ce       (CE && !ctrl_q.bypass), // RULE2 RULE16
      .srst     (LOCAL_RST),
      .set_val  (ctrl_q.set_val),
      .ddr      (ctrl_q.ddr_in),
      .swap     (swap),
      .d        (dly_out),
      .rise_evt (use_strobe ? rd_rise : rise_tick),
      .fall_evt (use_strobe ? rd_fall : fall_tick),
      .rise_q   (RISE_CAPTURE_OUT),
      .fall_q   (FALL_CAPTURE_OUT)
   );

   // ---------------------------------------------------------
   // output section
   // ---------------------------------------------------------
   logic out_phase;

   // right edge takes its write phase from the shifted strobe
   assign out_phase = IS_RIGHT ? STROBE_WRITE_CLK_SHIFTED // RULE13
                               : sclk_nx;

   always_ff @(posedge REF_CLK or posedge RESET) begin
      if (RESET) begin
         PAD_OUT <= 1'b0;
      end else if (LOCAL_RST) begin
         PAD_OUT <= ctrl_q.set_val; // RULE12
      end else if (CE) begin
         if (ctrl_q.ddr_out) begin
            PAD_OUT <= out_phase ? CORE_OUT_PRIMARY // RULE15 RULE9
                                 : CORE_OUT_SECONDARY;
         end else if (rise_tick) begin
            PAD_OUT <= CORE_OUT_PRIMARY; // RULE9
         end
      end
   end

   // ---------------------------------------------------------
   // tri-state section
   // ---------------------------------------------------------
   // unregistered mode still passes through one flop for timing
   always_ff @(posedge REF_CLK or posedge RESET) begin
      if (RESET) begin
         PAD_TRISTATE_OUT <= 1'b0;
      end else if (LOCAL_RST) begin
         PAD_TRISTATE_OUT <= ctrl_q.set_val; // RULE12
      end else if (!ctrl_q.tri_reg) begin
         PAD_TRISTATE_OUT <= CORE_TRISTATE_CTL; // RULE10
      end else if (CE && rise_tick) begin
         PAD_TRISTATE_OUT <= CORE_TRISTATE_CTL; // RULE10 RULE1
      end
   end

   // ---------------------------------------------------------
   // read channel
   // ---------------------------------------------------------
   pio_pkg::pio_stat_t stat;

   always_comb begin
      stat        = '0;
      stat.rise   = RISE_CAPTURE_OUT;
      stat.fall   = FALL_CAPTURE_OUT;
      stat.pad    = pad_q;
      stat.tri_st = PAD_TRISTATE_OUT;
      stat.phase  = sclk_q;
   end

   always_ff @(posedge REF_CLK or posedge RESET) begin
      if (RESET) begin
         S_AXI_ARREADY <= 1'b0;
         S_AXI_RVALID  <= 1'b0;
         S_AXI_RDATA   <= '0;
         S_AXI_RRESP   <= pio_pkg::RESP_OKAY;
      end else begin
         S_AXI_ARREADY <= !rvalid_d;
         S_AXI_RVALID  <= rvalid_d;
         if (ar_take) begin
            S_AXI_RRESP <= known(S_AXI_ARADDR) ? pio_pkg::RESP_OKAY
                                               : pio_pkg::RESP_SLVERR;
            unique case (S_AXI_ARADDR)
               pio_pkg::REG_CTRL: S_AXI_RDATA <= 32'(ctrl_q);
               pio_pkg::REG_DLY:  S_AXI_RDATA <= 32'(dly_q);
               pio_pkg::REG_DIV:  S_AXI_RDATA <= 32'(div_q);
               pio_pkg::REG_STAT: S_AXI_RDATA <= 32'(stat);
               default:           S_AXI_RDATA <= '0;
            endcase
         end
      end
   end

endmodule

// file: sim/pio_cell_assertions.sv
module pio_cell_assertions (
   // clock and reset
   input wire logic REF_CLK,
   input wire logic RESET,
   // core side
   input wire logic CE,
   input wire logic LOCAL_RST,
   input wire logic CORE_OUT_PRIMARY,
   input wire logic CORE_OUT_SECONDARY,
   input wire logic CORE_TRISTATE_CTL,
   input wire logic INPUT_BYPASS_DATA,
   input wire logic INPUT_BYPASS_CLOCK,
   input wire logic RISE_CAPTURE_OUT,
   input wire logic FALL_CAPTURE_OUT,
   // pad side
   input wire logic PAD_IN,
   input wire logic PAD_OUT,
   input wire logic PAD_TRISTATE_OUT
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking @(posedge REF_CLK); endclocking
   default disable iff (RESET);

   bypass_clock_a:
      assert property (INPUT_BYPASS_CLOCK == INPUT_BYPASS_DATA)
      else $error("bypass clock differs from data");
   bypass_data_a:
      assert property (INPUT_BYPASS_DATA |-> $past(PAD_IN))
      else $error("bypass data not from pad");
   local_reset_a:
      assert property (LOCAL_RST |=> PAD_OUT == PAD_TRISTATE_OUT
         && RISE_CAPTURE_OUT == PAD_OUT && FALL_CAPTURE_OUT == PAD_OUT)
      else $error("local reset left outputs apart");
   capture_hold_a:
      assert property (!CE && !LOCAL_RST |=> $stable(RISE_CAPTURE_OUT)
         && $stable(FALL_CAPTURE_OUT))
      else $error("capture moved with enable low");
   out_hold_a:
      assert property (!CE && !LOCAL_RST |=> $stable(PAD_OUT))
      else $error("pad output moved with enable low");
   out_source_a:
      assert property ($changed(PAD_OUT) && !$past(LOCAL_RST) |->
         PAD_OUT == $past(CORE_OUT_PRIMARY)
         || PAD_OUT == $past(CORE_OUT_SECONDARY))
      else $error("pad output not from core data");
   tri_source_a:
      assert property ($changed(PAD_TRISTATE_OUT) && !$past(LOCAL_RST)
         |-> PAD_TRISTATE_OUT == $past(CORE_TRISTATE_CTL))
      else $error("tri-state output not from core");
   reset_clear_a:
      assert property ($fell(RESET) |-> !(PAD_OUT || PAD_TRISTATE_OUT
         || RISE_CAPTURE_OUT || FALL_CAPTURE_OUT || INPUT_BYPASS_DATA))
      else $error("outputs not clear after reset");
endmodule

bind pio_cell pio_cell_assertions u_chk (
   .REF_CLK, .RESET, .CE, .LOCAL_RST, .CORE_OUT_PRIMARY,
   .CORE_OUT_SECONDARY, .CORE_TRISTATE_CTL, .INPUT_BYPASS_DATA,
   .INPUT_BYPASS_CLOCK, .RISE_CAPTURE_OUT, .FALL_CAPTURE_OUT,
   .PAD_IN, .PAD_OUT, .PAD_TRISTATE_OUT
);

// file: sim/pio_pad_model.sv
module pio_pad_model (
   // clock
   input  wire logic clk,
   // level or toggling source chosen by the bench
   input  wire logic ext_val,
   input  wire logic toggle,
   // lines into the cell
   output logic      pad_in,
   output logic      rd_strobe,
   output logic      wr_strobe,
   output logic      polarity
);
   timeunit 1ns;
   timeprecision 1ps;
   // strobes stand still: a bottom cell must not listen to them
   // read strobe low would stall capture, write strobe high would
   // force primary data every cycle, if either were obeyed
   assign rd_strobe = 1'b0;
   assign wr_strobe = 1'b1;
   assign polarity  = 1'b0;
   // source moves just after the edge, never on it
   initial pad_in = 1'b0;
   always @(posedge clk) begin
      pad_in <= toggle ? ~pad_in : ext_val;
   end
endmodule

// file: sim/testbench.sv
module testbench;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int FDLY = 8;
   logic        clk, rst, ce, lrst, d0, d1, td, ext, tog, prev;
   logic        awvalid, wvalid, bready, arvalid, rready;
   logic        awready, wready, bvalid, arready, rvalid;
   logic        byp_d, byp_c, rise_q, fall_q, pad_in, pad_out, pad_tri;
   logic        sr, sw, pol;
   logic [7:0]  awaddr, araddr;
   logic [31:0] wdata, rdata, v;
   logic [1:0]  bresp, rresp, r;
   int          n_errors = 0, total_checks = 0, cyc = 0, n;
   logic [7:0]  ra [4] = '{pio_pkg::REG_CTRL, pio_pkg::REG_DLY,
                           pio_pkg::REG_DIV, 8'h10};
   logic [31:0] rv [4] = '{32'h0, 32'h0, {24'h0, pio_pkg::DIV_RST}, 32'h0};
   logic [1:0]  rr [4] = '{2'h0, 2'h0, 2'h0, pio_pkg::RESP_SLVERR};
   logic [31:0] cfg [3] = '{32'h0, 32'h2, 32'h6};
   int          tap [3] = '{0, FDLY, FDLY + 31};

   pio_cell #(.EDGE(pio_pkg::EDGE_BOTTOM), .FIXED_DLY(FDLY)) dut (
      .REF_CLK(clk), .RESET(rst), .CE(ce), .LOCAL_RST(lrst),
      .CORE_OUT_PRIMARY(d0), .CORE_OUT_SECONDARY(d1),
      .CORE_TRISTATE_CTL(td), .INPUT_BYPASS_DATA(byp_d),
      .INPUT_BYPASS_CLOCK(byp_c), .RISE_CAPTURE_OUT(rise_q),
      .FALL_CAPTURE_OUT(fall_q), .PAD_IN(pad_in), .PAD_OUT(pad_out),
      .PAD_TRISTATE_OUT(pad_tri), .STROBE_READ_CLK_SHIFTED(sr),
      .STROBE_WRITE_CLK_SHIFTED(sw), .CAPTURE_POLARITY_CTL(pol),
      .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid),
      .S_AXI_AWREADY(awready), .S_AXI_WDATA(wdata),
      .S_AXI_WSTRB(4'hf), .S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready),
      .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready),
      .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid),
      .S_AXI_ARREADY(arready), .S_AXI_RDATA(rdata),
      .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready)
   );
   pio_pad_model pad (
      .clk(clk), .ext_val(ext), .toggle(tog), .pad_in(pad_in),
      .rd_strobe(sr), .wr_strobe(sw), .polarity(pol)
   );

   // ---------------------------------------------------------
   // clock, bus tasks, compares
   // ---------------------------------------------------------
   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end

   task automatic chk(input logic g, input logic e);
      total_checks++;
      if (g !== e) begin
         n_errors++;
         $display("mismatch at %0t: bit %b, want %b", $time, g, e);
      end
   endtask

   task automatic chkw(input logic [31:0] g, input logic [31:0] e);
      total_checks++;
      if (g !== e) begin
         n_errors++;
         $display("mismatch at %0t: word %h, want %h", $time, g, e);
      end
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d,
                     output logic [1:0] rs);
      logic ah, wh;
      ah = 1'b0;
      wh = 1'b0;
      @(posedge clk);
      awaddr  <= a;
      wdata   <= d;
      awvalid <= 1'b1;
      wvalid  <= 1'b1;
      bready  <= 1'b1;
      while (!(ah && wh)) begin
         @(posedge clk);
         if (!ah && awready === 1'b1) begin
            ah = 1'b1;
            awvalid <= 1'b0;
         end
         if (!wh && wready === 1'b1) begin
            wh = 1'b1;
            wvalid <= 1'b0;
         end
      end
      do @(posedge clk); while (bvalid !== 1'b1);
      rs = bresp;
      bready <= 1'b0;
   endtask

   task automatic rd(input logic [7:0] a, output logic [31:0] d,
                     output logic [1:0] rs);
      @(posedge clk);
      araddr  <= a;
      arvalid <= 1'b1;
      rready  <= 1'b1;
      do @(posedge clk); while (arready !== 1'b1);
      arvalid <= 1'b0;
      do @(posedge clk); while (rvalid !== 1'b1);
      d  = rdata;
      rs = rresp;
      rready <= 1'b0;
   endtask

   // edges from a pad change until the sdr capture shows it
   task automatic lat(input logic lv, output int cnt);
      cnt = 0;
      ext <= lv;
      do begin
         @(posedge clk);
         cnt++;
      end while (fall_q !== lv && cnt < 100);
   endtask

   task automatic final_report();
      $display("checks %0d errors %0d", total_checks, n_errors);
      if (n_errors == 0 && total_checks > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask

   // the 20000-cycle time limit lies far above the whole run of under 1000 cycles
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         n_errors++;
         final_report();
      end
   end

   // ---------------------------------------------------------
   // scenarios
   // ---------------------------------------------------------
   initial begin
      {rst, ce, lrst, d0, d1, td, ext, tog} = 8'h c0;
      {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
      {awaddr, araddr, wdata} = 48'h0;
      repeat (3) @(posedge clk);
      rst <= 1'b0;
      for (int i = 0; i < 4; i++) begin
         rd(ra[i], v, r);
         chkw(v, rv[i]);
         chkw({30'h0, r}, {30'h0, rr[i]});
      end
      wr(8'h10, 32'h1, r);
      chkw({30'h0, r}, {30'h0, pio_pkg::RESP_SLVERR});
      wr(pio_pkg::REG_DLY, 32'hffff_ffff, r);
      rd(pio_pkg::REG_DLY, v, r);
      chkw(v, 32'h0000_001f);
      // fixed and dynamic delay ahead of sdr capture
      foreach (cfg[i]) begin
         wr(pio_pkg::REG_CTRL, cfg[i], r);
         // old pad history must drain from the whole line first
         repeat (64) @(posedge clk);
         for (int k = 1; k >= 0; k--) begin
            lat(k[0], n);
            chk(n >= tap[i] + 2 && n <= tap[i] + 8, 1'b1);
         end
      end
      ce  <= 1'b0;
      ext <= 1'b1;
      repeat (60) @(posedge clk);
      chk(fall_q, 1'b0);
      ce <= 1'b1;
      repeat (60) @(posedge clk);
      chk(fall_q, 1'b1);
      wr(pio_pkg::REG_CTRL, 32'h08, r);
      for (int k = 1; k >= 0; k--) begin
         ext <= k[0];
         repeat (20) @(posedge clk);
         chk(rise_q, k[0]);
         chk(fall_q, k[0]);
      end
      wr(pio_pkg::REG_CTRL, 32'h01, r);
      tog <= 1'b1;
      @(posedge clk);
      prev = pad_in;
      repeat (12) begin
         @(posedge clk);
         chk(byp_d, prev);
         chk(byp_c, prev);
         prev = pad_in;
      end
      tog <= 1'b0;
      wr(pio_pkg::REG_CTRL, 32'h10, r);
      d0 <= 1'b1;
      repeat (4) @(posedge clk);
      n = 0;
      repeat (16) begin
         @(posedge clk);
         if (pad_out === 1'b1) n++;
      end
      chk(n == 8, 1'b1);
      for (int k = 0; k < 4; k++) begin
         wr(pio_pkg::REG_CTRL, k[1] ? 32'h20 : 32'h0, r);
         td <= ~k[0];
         repeat (8) @(posedge clk);
         chk(pad_tri, ~k[0]);
      end
      for (int k = 1; k >= 0; k--) begin
         wr(pio_pkg::REG_CTRL, k[0] ? 32'h40 : 32'h0, r);
         lrst <= 1'b1;
         @(posedge clk);
         lrst <= 1'b0;
         @(posedge clk);
         chk(pad_out, k[0]);
         chk(pad_tri, k[0]);
         chk(fall_q, k[0]);
      end
      final_report();
   end
endmodule
